/* File: hw/bcd_contact_driver.sv */
/*
 * Top of the bi-stable contact driver: power-up position read, pass
 * sampling of the request operands, one cell per contact, and the
 * contact self-test error with its event and target message.
 * Assumes passStrobe is a one-cycle pulse from the evaluation engine at
 * the start of each protection pass, and cycleStrobe a one-cycle pulse
 * with the first pass of each power-system cycle.
 */
`timescale 1ns/100ps

// Behaviour
// - Contact positions are read from the position sense after reset before any request is acted upon.
// - Each contact's commanded position is compared with its sensed position and a disagreement with no coil drive in progress raises the self-test error.
// - The self-test error drives an error operand, a one-cycle event pulse and a latched target message.
// - A close request drives the close coil and keeps it driven until the contact is closed or MAX_DRIVE_CYCLES run out, even if the request drops.
// - With the contact closed and no open request, further activity on the close request has no effect.
// - An open request drives the open coil and keeps it driven until the contact is open or MAX_DRIVE_CYCLES run out, even if the request drops.
// - With the contact open and no close request, further activity on the open request has no effect.
// - With both requests active, the per-contact dominance setting chooses close or open.
// - Requests are sampled once at the start of each protection pass, eight passes to a power-system cycle.
module bcd_contact_driver
	import bcd_pkg::*;
#(
	parameter int NUM_CONTACTS = NUM_CONTACTS_DEFAULT,
	parameter int MAX_DRIVE_CYCLES = COIL_MAX_OPERATE_CYCLES,
	parameter int SETTLE_CYCLES = POSITION_SETTLE_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic passStrobe,
	input wire logic cycleStrobe,
	input wire logic [NUM_CONTACTS-1:0] closeRequestSelect,
	input wire logic [NUM_CONTACTS-1:0] openRequestSelect,
	input wire logic [NUM_CONTACTS-1:0] conflictPrioritySelect,
	input wire logic [NUM_CONTACTS-1:0] contactPosition,
	input wire logic targetAck,
	output logic [NUM_CONTACTS-1:0] closeCoil,
	output logic [NUM_CONTACTS-1:0] openCoil,
	output logic [NUM_CONTACTS-1:0] commandedClosed,
	output logic positionsLoaded,
	output logic evalPass,
	output logic [PASS_INDEX_W-1:0] passIndex,
	output logic latchErrorOperand,
	output logic latchErrorEvent,
	output logic latchErrorTarget
);

	localparam int SW = $clog2(SETTLE_CYCLES + 1);
	localparam logic [SW-1:0] SETTLE_LAST = SW'(SETTLE_CYCLES - 1);

	bcd_init_e initState;
	bcd_init_e next_initState;
	logic [SW-1:0] settleCount;
	logic loadPosition;
	bcd_request_s sampledRequest [NUM_CONTACTS];
	logic [NUM_CONTACTS-1:0] discrepancy;
	logic anyDiscrepancy;

	// ------------------------------------------------------------------
	// Power-up position read
	// ------------------------------------------------------------------
	// Nothing downstream runs until the positions are loaded, so a
	// contact left closed across a power loss is not driven open.
	always_comb begin
		next_initState = initState;
		case (initState)
			INIT_HOLD: begin
				next_initState = INIT_SETTLE;
			end
			INIT_SETTLE: begin
				if (settleCount == SETTLE_LAST) begin
					next_initState = INIT_LOAD;
				end
			end
			INIT_LOAD: begin
				next_initState = INIT_RUN;
			end
			INIT_RUN: begin
				next_initState = INIT_RUN;
			end
			default: begin
				next_initState = INIT_HOLD;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			initState <= INIT_HOLD;
		end else begin
			initState <= next_initState;
		end
	end

	always_ff @(posedge clk) begin
		if (srst || initState != INIT_SETTLE) begin
			settleCount <= '0;
		end else begin
			settleCount <= settleCount + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			loadPosition <= 1'b0;
			positionsLoaded <= 1'b0;
		end else begin
			loadPosition <= (next_initState == INIT_LOAD);
			positionsLoaded <= (initState == INIT_LOAD) ||
				positionsLoaded;
		end
	end

	// ------------------------------------------------------------------
	// Pass sampling
	// ------------------------------------------------------------------
	// Requests are frozen at the pass start so every contact sees the
	// same snapshot; changes between passes are not seen until the next.
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < NUM_CONTACTS; i++) begin
				sampledRequest[i] <= REQUEST_IDLE;
			end
		end else if (passStrobe && positionsLoaded) begin
			for (int i = 0; i < NUM_CONTACTS; i++) begin
				sampledRequest[i] <= '{
					closeRequest: closeRequestSelect[i],
					openRequest: openRequestSelect[i],
					closeDominant: conflictPrioritySelect[i]
				};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			evalPass <= 1'b0;
		end else begin
			evalPass <= passStrobe & positionsLoaded;
		end
	end

	// Position of the current pass within the power-system cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			passIndex <= PASS_INDEX_RESET;
		end else if (passStrobe && cycleStrobe) begin
			passIndex <= PASS_INDEX_RESET;
		end else if (passStrobe) begin
			if (passIndex == PASS_INDEX_LAST) begin
				passIndex <= PASS_INDEX_RESET;
			end else begin
				passIndex <= passIndex + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Contacts
	// ------------------------------------------------------------------
	for (genvar g = 0; g < NUM_CONTACTS; g++) begin : gContact
		bcd_contact_cell #(
			.MAX_DRIVE_CYCLES(MAX_DRIVE_CYCLES)
		) uCell (
			.clk(clk),
			.srst(srst),
			.loadPosition(loadPosition),
			.applyPass(evalPass),
			.request(sampledRequest[g]),
			.position(contactPosition[g]),
			.closeCoil(closeCoil[g]),
			.openCoil(openCoil[g]),
			.commandedClosed(commandedClosed[g]),
			.discrepancy(discrepancy[g])
		);
	end

	// ------------------------------------------------------------------
	// Self-test error reporting
	// ------------------------------------------------------------------
	// No self-test error before the positions are read: the reset-time
	// command would otherwise disagree with a contact left closed.
	assign anyDiscrepancy = positionsLoaded & (|discrepancy);

	always_ff @(posedge clk) begin
		if (srst) begin
			latchErrorOperand <= 1'b0;
			latchErrorEvent <= 1'b0;
		end else begin
			latchErrorOperand <= anyDiscrepancy;
			latchErrorEvent <= anyDiscrepancy & ~latchErrorOperand;
		end
	end

	// Target stays up until acknowledged; a new error wins over the ack
	always_ff @(posedge clk) begin
		if (srst) begin
			latchErrorTarget <= 1'b0;
		end else if (anyDiscrepancy && !latchErrorOperand) begin
			latchErrorTarget <= 1'b1;
		end else if (targetAck) begin
			latchErrorTarget <= 1'b0;
		end
	end

endmodule : bcd_contact_driver

/* File: hw/bcd_pkg.sv */
/*
 * Shared constants, types and the request-resolution function for the
 * bi-stable contact driver.
 * Assumes a 50 MHz system clock and a protection-pass strobe supplied by
 * the logic-evaluation engine.
 */
package bcd_pkg;

	// ------------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------------
	localparam int CLK_FREQ_KHZ = 50000;
	// Longest coil energisation before the move is given up
	localparam int COIL_MAX_OPERATE_US = 10000;
	localparam int COIL_MAX_OPERATE_CYCLES =
		COIL_MAX_OPERATE_US * CLK_FREQ_KHZ / 1000;
	// Least settling time of the position sense before the power-up read
	localparam int POSITION_SETTLE_US = 20;
	localparam int POSITION_SETTLE_CYCLES =
		(POSITION_SETTLE_US * CLK_FREQ_KHZ + 999) / 1000;

	// ------------------------------------------------------------------
	// Protection pass bookkeeping
	// ------------------------------------------------------------------
	localparam int PASSES_PER_CYCLE = 8;
	localparam int PASS_INDEX_W = 3;
	localparam logic [PASS_INDEX_W-1:0] PASS_INDEX_RESET = 3'h0;
	localparam logic [PASS_INDEX_W-1:0] PASS_INDEX_LAST = 3'h7;

	// Contact_a and contact_c
	localparam int NUM_CONTACTS_DEFAULT = 2;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic closeRequest;
		logic openRequest;
		logic closeDominant;
	} bcd_request_s;

	localparam bcd_request_s REQUEST_IDLE = 3'h0;

	typedef enum logic [1:0] {
		INIT_HOLD,
		INIT_SETTLE,
		INIT_LOAD,
		INIT_RUN
	} bcd_init_e;

	// ------------------------------------------------------------------
	// Position asked for by a request pair; current when none is active
	// ------------------------------------------------------------------
	function automatic logic bcdResolveTarget(
		input bcd_request_s req,
		input logic current
	);
		logic target;
		target = current;
		if (req.closeRequest && req.openRequest) begin
			target = req.closeDominant;
		end else if (req.closeRequest) begin
			target = 1'b1;
		end else if (req.openRequest) begin
			target = 1'b0;
		end
		return target;
	endfunction : bcdResolveTarget

endpackage : bcd_pkg

/* File: hw/bcd_contact_cell.sv */
/*
 * One bi-stable contact: commanded position, sealed-in coil drive,
 * drive timeout and discrepancy flag.
 * Assumes requests are stable outside applyPass and that position is
 * high while the contact is closed.
 */
`timescale 1ns/100ps
module bcd_contact_cell
	import bcd_pkg::*;
#(
	parameter int MAX_DRIVE_CYCLES = COIL_MAX_OPERATE_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic loadPosition,
	input wire logic applyPass,
	input wire bcd_request_s request,
	input wire logic position,
	output logic closeCoil,
	output logic openCoil,
	output logic commandedClosed,
	output logic discrepancy
);

	localparam int CW = $clog2(MAX_DRIVE_CYCLES + 1);
	localparam logic [CW-1:0] COUNT_LAST = CW'(MAX_DRIVE_CYCLES - 1);

	logic moving;
	logic [CW-1:0] driveCount;
	logic next_commanded;
	logic next_moving;
	logic resolved;
	logic requestActive;

	// ------------------------------------------------------------------
	// Next commanded position and drive state
	// ------------------------------------------------------------------
	always_comb begin
		resolved = bcdResolveTarget(request, commandedClosed);
		requestActive = request.closeRequest | request.openRequest;
		next_commanded = commandedClosed;
		next_moving = moving;
		if (loadPosition) begin
			next_commanded = position;
			next_moving = 1'b0;
		end else begin
			if (applyPass) begin
				next_commanded = resolved;
			end
			// A request for the position already held is chatter
			if (applyPass && requestActive && resolved != position) begin
				next_moving = 1'b1;
			end
			if (next_commanded == position) begin
				next_moving = 1'b0;
			end else if (moving && driveCount == COUNT_LAST) begin
				// Give up so a stuck contact cannot burn its coil
				next_moving = 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			commandedClosed <= 1'b0;
			moving <= 1'b0;
		end else begin
			commandedClosed <= next_commanded;
			moving <= next_moving;
		end
	end

	always_ff @(posedge clk) begin
		if (srst || !next_moving || !moving) begin
			driveCount <= '0;
		end else begin
			driveCount <= driveCount + 1'b1;
		end
	end

	// Sealed drive; released on the clock after the target position is sensed
	always_ff @(posedge clk) begin
		if (srst) begin
			closeCoil <= 1'b0;
			openCoil <= 1'b0;
		end else begin
			closeCoil <= next_moving & next_commanded & ~position;
			openCoil <= next_moving & ~next_commanded & position;
		end
	end

	always_ff @(posedge clk) begin
		if (srst || loadPosition) begin
			discrepancy <= 1'b0;
		end else begin
			discrepancy <= ~next_moving & (next_commanded != position);
		end
	end

endmodule : bcd_contact_cell

/* File: tb/bcd_contact_driver_sva.sv */
/*
 * Port checker for the bi-stable contact driver.
 * Assumes single clock, srst synchronous high, bound onto the top.
 */
`timescale 1ns/100ps
module bcd_contact_driver_sva
	import bcd_pkg::*;
#(
	parameter int NUM_CONTACTS = 2,
	parameter int MAX_DRIVE_CYCLES = 20,
	parameter int SETTLE_CYCLES = 4
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic passStrobe,
	input wire logic cycleStrobe,
	input wire logic [NUM_CONTACTS-1:0] closeRequestSelect,
	input wire logic [NUM_CONTACTS-1:0] openRequestSelect,
	input wire logic [NUM_CONTACTS-1:0] conflictPrioritySelect,
	input wire logic [NUM_CONTACTS-1:0] contactPosition,
	input wire logic targetAck,
	input wire logic [NUM_CONTACTS-1:0] closeCoil,
	input wire logic [NUM_CONTACTS-1:0] openCoil,
	input wire logic [NUM_CONTACTS-1:0] commandedClosed,
	input wire logic positionsLoaded,
	input wire logic evalPass,
	input wire logic [PASS_INDEX_W-1:0] passIndex,
	input wire logic latchErrorOperand,
	input wire logic latchErrorEvent,
	input wire logic latchErrorTarget
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	a_pass_evals: assert property (
		passStrobe && positionsLoaded |=> evalPass)
		else $error("pass not evaluated");
	a_early_idle: assert property (
		!positionsLoaded |-> !(|closeCoil) && !(|openCoil))
		else $error("coil before load");
	a_load_copies: assert property (
		$rose(positionsLoaded) |->
		commandedClosed == $past(contactPosition))
		else $error("load mismatch");
	a_close_cmd: assert property (
		passStrobe && positionsLoaded && closeRequestSelect[0] &&
		!openRequestSelect[0] |-> ##2 commandedClosed[0])
		else $error("close not commanded");
	a_chatter_kept: assert property (
		passStrobe && positionsLoaded && !evalPass &&
		!openRequestSelect[0] && commandedClosed[0] &&
		contactPosition[0] |-> ##2 commandedClosed[0] && !openCoil[0])
		else $error("chatter acted on");
	a_prio_wins: assert property (
		passStrobe && positionsLoaded && closeRequestSelect[0] &&
		openRequestSelect[0] |->
		##2 commandedClosed[0] == $past(conflictPrioritySelect[0], 2))
		else $error("priority ignored");
	a_coils_apart: assert property (
		!(|(closeCoil & openCoil)))
		else $error("both coils on");
	a_coil_settled: assert property (
		(closeCoil & $past(contactPosition, 2) &
		$past(contactPosition)) == 0 &&
		(openCoil & ~$past(contactPosition, 2) &
		~$past(contactPosition)) == 0)
		else $error("coil on at target");
	a_close_release: assert property (
		$fell(closeCoil[1]) |-> contactPosition[1] || openCoil[1] or
		##[1:3] latchErrorOperand)
		else $error("close seal lost");
	a_open_release: assert property (
		$fell(openCoil[0]) |-> !contactPosition[0] || closeCoil[0] or
		##[1:3] latchErrorOperand)
		else $error("open seal lost");
	a_err_cause: assert property (
		$rose(latchErrorOperand) |->
		$past(commandedClosed != contactPosition, 2))
		else $error("error without cause");
	a_err_flags: assert property (
		$rose(latchErrorOperand) |->
		latchErrorEvent && latchErrorTarget ##1 !latchErrorEvent)
		else $error("error signalling");
endmodule : bcd_contact_driver_sva

bind bcd_contact_driver bcd_contact_driver_sva #(
	.NUM_CONTACTS(NUM_CONTACTS),
	.MAX_DRIVE_CYCLES(MAX_DRIVE_CYCLES),
	.SETTLE_CYCLES(SETTLE_CYCLES)
) u_sva (
	.clk(clk),
	.srst(srst),
	.passStrobe(passStrobe),
	.cycleStrobe(cycleStrobe),
	.closeRequestSelect(closeRequestSelect),
	.openRequestSelect(openRequestSelect),
	.conflictPrioritySelect(conflictPrioritySelect),
	.contactPosition(contactPosition),
	.targetAck(targetAck),
	.closeCoil(closeCoil),
	.openCoil(openCoil),
	.commandedClosed(commandedClosed),
	.positionsLoaded(positionsLoaded),
	.evalPass(evalPass),
	.passIndex(passIndex),
	.latchErrorOperand(latchErrorOperand),
	.latchErrorEvent(latchErrorEvent),
	.latchErrorTarget(latchErrorTarget)
);

/* File: tb/bcd_contact_model.sv */
/*
 * Behavioural bi-stable contacts with close and open coils.
 * Assumes coils are sampled on the rising clock; stuck pins a contact.
 */
`timescale 1ns/100ps
module bcd_contact_model
	import bcd_pkg::*;
#(
	parameter int NUM_CONTACTS = 2,
	parameter int MOVE_CYCLES = 6,
	parameter logic [NUM_CONTACTS-1:0] INIT_POSITION = '0
) (
	input wire logic clk,
	input wire logic [NUM_CONTACTS-1:0] closeCoil,
	input wire logic [NUM_CONTACTS-1:0] openCoil,
	input wire logic [NUM_CONTACTS-1:0] stuck,
	output logic [NUM_CONTACTS-1:0] position
);
	int moveCount [NUM_CONTACTS];
	// Position kept with no coil drive, as a latching contact does
	initial position = INIT_POSITION;
	always @(posedge clk) begin
		for (int i = 0; i < NUM_CONTACTS; i++) begin
			if (stuck[i] || closeCoil[i] == openCoil[i]) begin
				moveCount[i] <= 0;
			end else if (moveCount[i] == MOVE_CYCLES + i) begin
				position[i] <= closeCoil[i];
				moveCount[i] <= 0;
			end else begin
				moveCount[i] <= moveCount[i] + 1;
			end
		end
	end
endmodule : bcd_contact_model

/* File: tb/tb_top.sv */
/*
 * Self-checking bench for the bi-stable contact driver.
 * Assumes short drive and settle counts; inputs move on falling edges.
 */
`timescale 1ns/100ps
module tb_top;
	import bcd_pkg::*;
	localparam int N = 2;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic passStrobe = 1'b0;
	logic cycleStrobe = 1'b0;
	logic targetAck = 1'b0;
	logic [N-1:0] closeReq = '0, openReq = '0, prio = '0, stuck = '0;
	logic [N-1:0] pos, closeCoil, openCoil, cmd;
	logic loaded, evalPass, errOp, errEvent, errTarget;
	logic sawEvent = 1'b0;
	logic [PASS_INDEX_W-1:0] passIndex;
	int failures = 0;
	int compares = 0;
	always #10 clk = ~clk;
	bcd_contact_driver #(.NUM_CONTACTS(N), .MAX_DRIVE_CYCLES(20),
		.SETTLE_CYCLES(4)) u_bcd_contact_driver (.clk(clk), .srst(srst),
		.passStrobe(passStrobe), .cycleStrobe(cycleStrobe),
		.closeRequestSelect(closeReq), .openRequestSelect(openReq),
		.conflictPrioritySelect(prio), .contactPosition(pos),
		.targetAck(targetAck), .closeCoil(closeCoil), .openCoil(openCoil),
		.commandedClosed(cmd), .positionsLoaded(loaded), .evalPass(evalPass),
		.passIndex(passIndex), .latchErrorOperand(errOp),
		.latchErrorEvent(errEvent), .latchErrorTarget(errTarget));
	bcd_contact_model #(.NUM_CONTACTS(N), .INIT_POSITION(2'b10))
		u_bcd_contact_model (.clk(clk), .closeCoil(closeCoil),
		.openCoil(openCoil), .stuck(stuck), .position(pos));

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic stop_test;
		if (failures == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test
	task automatic check(input string what, input logic [3:0] exp,
		input logic [3:0] seen);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic pass(input logic [N-1:0] c, o, p, input logic cyc);
		@(negedge clk);
		closeReq = c;
		openReq = o;
		prio = p;
		cycleStrobe = cyc;
		passStrobe = 1'b1;
		@(negedge clk);
		passStrobe = 1'b0;
		cycleStrobe = 1'b0;
		repeat (3) @(negedge clk);
	endtask : pass
	// 0 loaded, 1 coils idle, 2 error up, 3 error down
	task automatic await(input int what);
		int i;
		for (i = 0; i < 80; i++) begin
			sawEvent = sawEvent | errEvent;
			if (what == 0 && loaded === 1'b1) break;
			if (what == 1 && (closeCoil | openCoil) === 2'b00) break;
			if (what == 2 && errOp === 1'b1) break;
			if (what == 3 && errOp === 1'b0) break;
			@(negedge clk);
		end
		if (i == 80) begin
			failures++;
			stop_test();
		end
	endtask : await

	initial begin
		repeat (8) @(negedge clk);
		srst = 1'b0;
		pass(2'b01, 2'b00, 2'b00, 1'b0);
		closeReq = '0;
		await(0);
		check("loaded command", 4'h2, {2'b00, cmd});
		check("coils at load", 4'h0, {closeCoil, openCoil});
		check("error at load", 4'h0, {2'b00, errOp, errTarget});
		pass(2'b00, 2'b00, 2'b00, 1'b1);
		check("pass index", 4'h0, {1'b0, passIndex});
		pass(2'b01, 2'b00, 2'b00, 1'b0);
		closeReq = '0;
		check("pass index", 4'h1, {1'b0, passIndex});
		check("close drive", 4'h1, {2'b00, closeCoil});
		await(1);
		check("closed", 4'h3, {2'b00, pos});
		pass(2'b01, 2'b00, 2'b00, 1'b0);
		check("close chatter", 4'h0, {closeCoil, openCoil});
		pass(2'b00, 2'b11, 2'b00, 1'b0);
		openReq = '0;
		check("open drive", 4'h3, {2'b00, openCoil});
		await(1);
		check("opened", 4'h0, {2'b00, pos});
		pass(2'b00, 2'b11, 2'b00, 1'b0);
		check("open chatter", 4'h0, {closeCoil, openCoil});
		for (int p = 1; p < 3; p++) begin
			pass(2'b11, 2'b11, p[1:0], 1'b0);
			await(1);
			check("conflict", {p[1:0], p[1:0]}, {cmd, pos});
		end
		for (int s = 1; s >= 0; s--) begin
			pass({N{s[0]}}, {N{~s[0]}}, 2'b00, 1'b0);
			await(1);
			check("follow level", {4{s[0]}}, {cmd, pos});
		end
		pass(2'b01, 2'b10, 2'b00, 1'b0);
		await(1);
		check("normally closed", 4'h5, {cmd, pos});
		stuck = 2'b10;
		pass(2'b10, 2'b00, 2'b00, 1'b0);
		closeReq = '0;
		await(2);
		check("error raise", 4'he, {errOp, errTarget, sawEvent, closeCoil[1]});
		targetAck = 1'b1;
		@(negedge clk);
		targetAck = 1'b0;
		@(negedge clk);
		check("target ack", 4'h2, {2'b00, errOp, errTarget});
		stuck = 2'b00;
		pass(2'b00, 2'b10, 2'b00, 1'b0);
		openReq = '0;
		await(3);
		check("error clear", 4'h1, {2'b00, errOp, pos[0]});
		// Make first on contact_c, break contact_a only after it has closed
		pass(2'b10, 2'b00, 2'b00, 1'b0);
		await(1);
		check("overlap", 4'hf, {cmd, pos});
		pass(2'b00, 2'b01, 2'b00, 1'b0);
		await(1);
		check("break after make", 4'ha, {cmd, pos});
		stop_test();
	end
endmodule : tb_top
